// >>> design/ipv_pkg.sv
package ipv_pkg;

	// -------------------------------------------------------------
	// Promote-select codes
	// -------------------------------------------------------------
	localparam logic [3:0] IPV_PSEL_TOF   = 4'h0;
	localparam logic [3:0] IPV_PSEL_PAOV  = 4'h1;
	localparam logic [3:0] IPV_PSEL_PAE   = 4'h2;
	localparam logic [3:0] IPV_PSEL_SPI   = 4'h3;
	localparam logic [3:0] IPV_PSEL_SCI   = 4'h4;
	localparam logic [3:0] IPV_PSEL_RSVD  = 4'h5;
	localparam logic [3:0] IPV_PSEL_IRQ   = 4'h6;
	localparam logic [3:0] IPV_PSEL_RTI   = 4'h7;
	localparam logic [3:0] IPV_PSEL_RESET = IPV_PSEL_IRQ;

	// -------------------------------------------------------------
	// Maskable source indices, fixed rank order (0 is highest)
	// -------------------------------------------------------------
	localparam int IPV_NMASK   = 15;
	localparam int IPV_S_IRQ   = 0;
	localparam int IPV_S_RTI   = 1;
	localparam int IPV_S_CAP1  = 2;
	localparam int IPV_S_CMP1  = 5;
	localparam int IPV_S_C4C5  = 9;
	localparam int IPV_S_TOF   = 10;
	localparam int IPV_S_PAOV  = 11;
	localparam int IPV_S_PAE   = 12;
	localparam int IPV_S_SPI   = 13;
	localparam int IPV_S_SCI   = 14;

	// -------------------------------------------------------------
	// Vector addresses (first byte of each pair)
	// -------------------------------------------------------------
	localparam logic [15:0] IPV_VEC_SCI   = 16'hffd6;
	localparam logic [15:0] IPV_VEC_RTI   = 16'hfff0;
	localparam logic [15:0] IPV_VEC_IRQ   = 16'hfff2;
	localparam logic [15:0] IPV_VEC_NMI   = 16'hfff4;
	localparam logic [15:0] IPV_VEC_SOFT  = 16'hfff6;
	localparam logic [15:0] IPV_VEC_ILL   = 16'hfff8;
	localparam logic [15:0] IPV_VEC_COP   = 16'hfffa;
	localparam logic [15:0] IPV_VEC_CMF   = 16'hfffc;
	localparam logic [15:0] IPV_VEC_RST   = 16'hfffe;
	localparam logic [15:0] IPV_VEC_STEP  = 16'h0002;

	// -------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------
	typedef struct packed {
		logic rx_full;
		logic rx_overrun;
		logic tx_empty;
		logic tx_done;
		logic idle_line;
	} ipv_sci_s;

	typedef struct packed {
		logic irq;
		logic periodic;
		logic cap1;
		logic cap2;
		logic cap3;
		logic cmp1;
		logic cmp2;
		logic cmp3;
		logic cmp4;
		logic cap4_cmp5;
		logic timer_ovf;
		logic accum_ovf;
		logic accum_edge;
		logic spi_done;
	} ipv_req_s;

	typedef struct packed {
		logic periodic_irq_en;
		logic cap1_irq_en;
		logic cap2_irq_en;
		logic cap3_irq_en;
		logic cmp1_irq_en;
		logic cmp2_irq_en;
		logic cmp3_irq_en;
		logic cmp4_irq_en;
		logic cap4_cmp5_irq_en;
		logic timer_ovf_irq_en;
		logic accum_ovf_irq_en;
		logic accum_edge_irq_en;
		logic spi_done_irq_en;
	} ipv_en_s;

	typedef enum logic [3:0] {
		IPV_RX_IDLE = 4'h1,
		IPV_RX_ARMED = 4'h2,
		IPV_RX_SPARE = 4'h4,
		IPV_RX_UNUSED = 4'h8
	} ipv_rxclr_e;

endpackage

// >>> design/ipv_top.sv
// Functional notes
// [R1] Codes 0-4 promote TOF, PAOV, PAE, SPI, SCI
// [R2] Code 5 behaves as 6, promoting IRQ
// [R3] Code 7 RTI; 8-15 captures, compares, C4/C5
// [R4] 25 sources share 21 vector addresses
// [R5] Maskable sources need global I mask clear
// [R6] Trap, soft trap, X pin ignore I mask
// [R7] Status read then data read clears rx full
// [R8] Five SCI sources, one vector, local enables
// [R9] SPI, PAE, PAOV, TOF vectors, locally gated
// [R10] C4/C5 through RTI vectors, locally gated
// [R11] IRQ unmasked locally; X pin by X bit
// [R12] Watchdog, clock monitor, reset vectors ordered
// [R13] Promote field writable only with I set
// [R14] Reset loads promote field with IRQ code
// [R15] Fixed maskable order when nothing promoted
// [R16] Promotion changes rank, never vector address
// [R17] Reserved vectors below SCI never selected
`timescale 1ns/1ps
`default_nettype none

module ipv_top
	import ipv_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       i_mask,
	input  wire logic       x_mask,
	input  wire logic       psel_we,
	input  wire logic [3:0] psel_wdata,
	input  wire ipv_req_s   req,
	input  wire ipv_en_s    en,
	input  wire ipv_sci_s   sci_evt,
	input  wire logic       rx_irq_en,
	input  wire logic       tx_empty_irq_en,
	input  wire logic       tx_done_irq_en,
	input  wire logic       idle_line_irq_en,
	input  wire logic       sci_status_rd,
	input  wire logic       sci_data_rd,
	input  wire logic       nonmask_irq_pin,
	input  wire logic       soft_trap,
	input  wire logic       illegal_op,
	input  wire logic       ext_reset,
	input  wire logic       clk_monitor_fail,
	input  wire logic       clk_monitor_en,
	input  wire logic       watchdog_fail,
	input  wire logic       watchdog_disable,
	output logic [3:0]      priority_misc_reg,
	output logic            rx_full_flag,
	output logic            vec_valid,
	output logic [15:0]     vec_addr
);

	// ---------------------------------------------------------
	// Promote-select field
	// ---------------------------------------------------------
	// Writes with I clear would race the arbiter, so they drop
	always_ff @(posedge clk) begin
		if (srst) begin
			priority_misc_reg <= IPV_PSEL_RESET; // [R14]
		end else if (psel_we && i_mask) begin
			priority_misc_reg <= psel_wdata; // [R13]
		end
	end

	// ---------------------------------------------------------
	// Receive-full flag and automatic clearing
	// ---------------------------------------------------------
	ipv_rxclr_e rx_state;
	logic       next_rx_full;

	always_comb begin
		// A bare data read, with no status read armed, keeps the flag
		next_rx_full = rx_full_flag;
		if (rx_state == IPV_RX_ARMED && sci_data_rd) begin
			next_rx_full = 1'b0; // [R7]
		end
		// A new frame in the clearing cycle is kept
		if (sci_evt.rx_full) begin
			next_rx_full = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_full_flag <= 1'b0;
		end else begin
			rx_full_flag <= next_rx_full;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_state <= IPV_RX_IDLE;
		end else begin
			case (rx_state)
				IPV_RX_IDLE: begin
					if (sci_status_rd && rx_full_flag) begin
						rx_state <= IPV_RX_ARMED; // [R7]
					end
				end
				IPV_RX_ARMED: begin
					if (sci_data_rd) begin
						rx_state <= IPV_RX_IDLE;
					end
				end
				default: rx_state <= IPV_RX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------
	// Gated maskable requests
	// ---------------------------------------------------------
	logic [IPV_NMASK-1:0] live;
	logic                 sci_live;

	always_comb begin
		// All five serial causes share a single request line
		sci_live = ((rx_full_flag | sci_evt.rx_overrun) & rx_irq_en)
			| (sci_evt.tx_empty & tx_empty_irq_en)
			| (sci_evt.tx_done & tx_done_irq_en)
			| (sci_evt.idle_line & idle_line_irq_en); // [R8]
		live = {sci_live,
			req.spi_done   & en.spi_done_irq_en,
			req.accum_edge & en.accum_edge_irq_en,
			req.accum_ovf  & en.accum_ovf_irq_en,
			req.timer_ovf  & en.timer_ovf_irq_en,
			req.cap4_cmp5  & en.cap4_cmp5_irq_en,
			req.cmp4       & en.cmp4_irq_en,
			req.cmp3       & en.cmp3_irq_en,
			req.cmp2       & en.cmp2_irq_en,
			req.cmp1       & en.cmp1_irq_en,
			req.cap3       & en.cap3_irq_en,
			req.cap2       & en.cap2_irq_en,
			req.cap1       & en.cap1_irq_en,
			req.periodic   & en.periodic_irq_en,
			req.irq}; // [R9] [R10] [R11]
		if (i_mask) begin
			live = '0; // [R5]
		end
	end

	// ---------------------------------------------------------
	// Promotion decode and arbitration
	// ---------------------------------------------------------
	// A promoted source that is not live falls back to fixed order
	logic [3:0] promo;

	always_comb begin
		case (priority_misc_reg)
			IPV_PSEL_TOF:  promo = 4'(IPV_S_TOF); // [R1]
			IPV_PSEL_PAOV: promo = 4'(IPV_S_PAOV);
			IPV_PSEL_PAE:  promo = 4'(IPV_S_PAE);
			IPV_PSEL_SPI:  promo = 4'(IPV_S_SPI);
			IPV_PSEL_SCI:  promo = 4'(IPV_S_SCI);
			IPV_PSEL_RSVD: promo = 4'(IPV_S_IRQ); // [R2]
			IPV_PSEL_IRQ:  promo = 4'(IPV_S_IRQ);
			IPV_PSEL_RTI:  promo = 4'(IPV_S_RTI); // [R3]
			// Codes 8-15 map onto cap1 upward in fixed order
			default: promo = 4'(priority_misc_reg - 4'h8
				+ 4'(IPV_S_CAP1)); // [R3]
		endcase
	end

	// Addresses are derived by rank, so no reserved slot can appear
	// Vector of maskable index i; SCI is the lowest
	function automatic logic [15:0] ipv_mvec(input logic [3:0] i);
		logic [15:0] d;
		d = 16'(4'(IPV_S_SCI) - i);
		return IPV_VEC_SCI + 16'(d * IPV_VEC_STEP); // [R16] [R17]
	endfunction

	logic [15:0] next_vec;
	logic        next_valid;
	logic        found;

	always_comb begin
		next_vec   = IPV_VEC_RST;
		next_valid = 1'b1;
		found      = 1'b0;
		// Resets and non-maskable sources outrank all else [R4]
		if (ext_reset) begin
			next_vec = IPV_VEC_RST; // [R12]
		end else if (clk_monitor_fail && clk_monitor_en) begin
			next_vec = IPV_VEC_CMF; // [R12]
		end else if (watchdog_fail && !watchdog_disable) begin
			next_vec = IPV_VEC_COP; // [R12]
		end else if (nonmask_irq_pin && !x_mask) begin
			next_vec = IPV_VEC_NMI; // [R6] [R11]
		end else if (illegal_op) begin
			next_vec = IPV_VEC_ILL; // [R6]
		end else if (soft_trap) begin
			next_vec = IPV_VEC_SOFT; // [R6]
		end else if (live[promo]) begin
			next_vec = ipv_mvec(promo); // [R16]
		end else begin
			next_valid = 1'b0;
			for (int i = 0; i < IPV_NMASK; i++) begin
				if (!found && live[i]) begin
					found    = 1'b1;
					next_vec = ipv_mvec(4'(i)); // [R15]
				end
			end
			next_valid = found;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			vec_valid <= 1'b0;
			vec_addr  <= IPV_VEC_RST;
		end else begin
			vec_valid <= next_valid;
			vec_addr  <= next_vec;
		end
	end

endmodule

`default_nettype wire

// >>> sim/ipv_props.sv
`timescale 1ns/1ps
`default_nettype none
module ipv_props
	import ipv_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        i_mask,
	input wire logic        x_mask,
	input wire logic        psel_we,
	input wire logic [3:0]  psel_wdata,
	input wire ipv_sci_s    sci_evt,
	input wire logic        nonmask_irq_pin,
	input wire logic        illegal_op,
	input wire logic        ext_reset,
	input wire logic [3:0]  priority_misc_reg,
	input wire logic        rx_full_flag,
	input wire logic        vec_valid,
	input wire logic [15:0] vec_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire logic xp = nonmask_irq_pin & ~x_mask;

	property p_rst;
		$fell(srst) |-> priority_misc_reg == 4'h6 && !vec_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset");
	property p_wr;
		psel_we && i_mask |=> priority_misc_reg == $past(psel_wdata);
	endproperty
	a_wr: assert property (p_wr) else $error("write lost");
	property p_hold;
		!(psel_we && i_mask) |=> $stable(priority_misc_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("write taken");
	property p_mask;
		i_mask |=> !vec_valid || vec_addr >= 16'hfff4;
	endproperty
	a_mask: assert property (p_mask) else $error("mask leak");
	property p_trap;
		illegal_op && !xp |=> vec_valid && vec_addr >= 16'hfff8;
	endproperty
	a_trap: assert property (p_trap) else $error("trap lost");
	property p_nonmask_irq_pin;
		xp |=> vec_valid && (vec_addr == 16'hfff4 || vec_addr >= 16'hfffa);
	endproperty
	a_nonmask_irq_pin: assert property (p_nonmask_irq_pin) else $error("pin lost");
	property p_ext;
		ext_reset |=> vec_valid && vec_addr == 16'hfffe;
	endproperty
	a_ext: assert property (p_ext) else $error("reset vec");
	property p_rsvd;
		vec_valid |-> vec_addr >= 16'hffd6 && !vec_addr[0];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("bad vec");
	property p_set;
		sci_evt.rx_full |=> rx_full_flag;
	endproperty
	a_set: assert property (p_set) else $error("flag set");
endmodule
bind ipv_top ipv_props u_props (
	.clk(clk),
	.srst(srst),
	.i_mask(i_mask),
	.x_mask(x_mask),
	.psel_we(psel_we),
	.psel_wdata(psel_wdata),
	.sci_evt(sci_evt),
	.nonmask_irq_pin(nonmask_irq_pin),
	.illegal_op(illegal_op),
	.ext_reset(ext_reset),
	.priority_misc_reg(priority_misc_reg),
	.rx_full_flag(rx_full_flag),
	.vec_valid(vec_valid),
	.vec_addr(vec_addr)
);
`default_nettype wire

// >>> sim/ipv_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipv_cpu_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [1:0] gap,
	output logic            status_rd,
	output logic            data_rd
);
	initial begin
		status_rd = 1'b0;
		data_rd = 1'b0;
	end
	// Status then data read, as a service routine does; gap varies
	always @(posedge go) begin
		@(negedge clk) status_rd = 1'b1;
		@(negedge clk) status_rd = 1'b0;
		repeat (gap) @(negedge clk);
		data_rd = 1'b1;
		@(negedge clk) data_rd = 1'b0;
	end
endmodule
`default_nettype wire

// >>> sim/tb_interrupt_priority_vector_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_priority_vector_logic
	import ipv_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        i_mask = 1'b1;
	logic        x_mask = 1'b1;
	logic        psel_we = 1'b0;
	logic [3:0]  psel_wdata = 4'h0;
	ipv_req_s    req = '0;
	ipv_en_s     en = '0;
	ipv_sci_s    sci_evt = '0;
	logic [3:0]  sen = 4'h0;
	logic [5:0]  nm = 6'h00;
	logic [1:0]  ce = 2'h0;
	logic        go = 1'b0;
	logic [1:0]  gap = 2'h0;
	logic [3:0]  ps_m = 4'h6;
	logic        fl_m = 1'b0;
	logic [3:0]  priority_misc_reg;
	logic [15:0] vec_addr;
	logic        sci_status_rd;
	logic        sci_data_rd;
	logic        rx_full_flag;
	logic        vec_valid;
	int          miscompares = 0;
	int          n_compared = 0;
	int          n;

	always #5 clk = ~clk;

	ipv_top DUT (
		.clk(clk),
		.srst(srst),
		.i_mask(i_mask),
		.x_mask(x_mask),
		.psel_we(psel_we),
		.psel_wdata(psel_wdata),
		.req(req),
		.en(en),
		.sci_evt(sci_evt),
		.sci_status_rd(sci_status_rd),
		.sci_data_rd(sci_data_rd),
		.rx_irq_en(sen[3]),
		.tx_empty_irq_en(sen[2]),
		.tx_done_irq_en(sen[1]),
		.idle_line_irq_en(sen[0]),
		.ext_reset(nm[5]),
		.clk_monitor_fail(nm[4]),
		.watchdog_fail(nm[3]),
		.nonmask_irq_pin(nm[2]),
		.illegal_op(nm[1]),
		.soft_trap(nm[0]),
		.clk_monitor_en(ce[1]),
		.watchdog_disable(ce[0]),
		.priority_misc_reg(priority_misc_reg),
		.rx_full_flag(rx_full_flag),
		.vec_valid(vec_valid),
		.vec_addr(vec_addr)
	);
	ipv_cpu_model u_cpu (
		.clk(clk),
		.go(go),
		.gap(gap),
		.status_rd(sci_status_rd),
		.data_rd(sci_data_rd)
	);

	// Expected receive flag feeds the serial request alongside overrun
	function automatic logic [16:0] exp_vec();
		logic [14:0] lv;
		int          p;
		lv[0] = req.irq;
		for (int k = 1; k < 14; k++)
			lv[k] = req[13 - k] & en[13 - k];
		lv[14] = (fl_m | sci_evt.rx_overrun) & sen[3]
			| sci_evt.tx_empty & sen[2]
			| sci_evt.tx_done & sen[1] | sci_evt.idle_line & sen[0];
		p = ps_m < 5 ? ps_m + 10 : ps_m < 7 ? 0 : ps_m - 6;
		if (nm[5]) return {1'b1, 16'hfffe};
		if (nm[4] && ce[1]) return {1'b1, 16'hfffc};
		if (nm[3] && !ce[0]) return {1'b1, 16'hfffa};
		if (nm[2] && !x_mask) return {1'b1, 16'hfff4};
		if (nm[1]) return {1'b1, 16'hfff8};
		if (nm[0]) return {1'b1, 16'hfff6};
		if (i_mask) return 17'h0;
		if (lv[p]) return {1'b1, 16'hfff2 - 16'(2 * p)};
		for (int k = 0; k < 15; k++)
			if (lv[k]) return {1'b1, 16'hfff2 - 16'(2 * k)};
		return 17'h0;
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic step();
		logic [16:0] e;
		e = exp_vec();
		if (psel_we && i_mask) ps_m = psel_wdata;
		@(negedge clk);
		chk_vec(e);
		chk_psel(ps_m);
	endtask

	task automatic chk_vec(input logic [16:0] e);
		chk(16'(vec_valid), 16'(e[16]));
		if (e[16]) chk(vec_addr, e[15:0]);
	endtask

	task automatic chk_psel(input logic [3:0] e);
		chk(16'(priority_misc_reg), 16'(e));
	endtask

	task automatic chk_flag(input logic e);
		chk(16'(rx_full_flag), 16'(e));
	endtask

	task automatic results();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		void'($urandom(79406));
		repeat (4) @(negedge clk);
		srst = 1'b0;
		chk_psel(4'h6);
		chk(vec_addr, 16'hfffe);
		chk_vec(17'h0);
		chk_flag(1'b0);
		req = '1;
		en = '1;
		sci_evt = 5'h0f;
		sen = 4'hf;
		for (int c = 0; c < 16; c++) begin
			i_mask = 1'b1;
			psel_we = 1'b1;
			psel_wdata = 4'(c);
			step();
			psel_we = 1'b0;
			i_mask = 1'b0;
			step();
		end
		psel_we = 1'b1;
		psel_wdata = 4'h3;
		step();
		$display("test promote done");
		for (int t = 0; t < 1500; t++) begin
			{i_mask, x_mask, psel_we, ce} = 5'($urandom);
			psel_wdata = 4'($urandom);
			req = 14'($urandom & $urandom & $urandom);
			en = 13'($urandom);
			sci_evt = 5'($urandom) & 5'h0f;
			sen = 4'($urandom);
			nm = $urandom % 3 == 0 ? 6'($urandom & $urandom) : 6'h00;
			step();
		end
		$display("test random done");
		{i_mask, psel_we, nm} = 8'h80;
		req = '0;
		sci_evt = 5'h10;
		@(negedge clk);
		// Receive flag alone must raise the shared serial vector
		{i_mask, sen, sci_evt} = 10'h100;
		fl_m = 1'b1;
		step();
		chk_flag(1'b1);
		gap = 2'($urandom);
		go = 1'b1;
		for (n = 0; n < 12 && rx_full_flag !== 1'b0; n++)
			@(negedge clk);
		go = 1'b0;
		fl_m = 1'b0;
		chk_flag(1'b0);
		step();
		$display("test rx clear done");
		results();
	end
endmodule
`default_nettype wire
